// file: hw/increment_or_move_instructions.sv
// What this block does
// - increment opcode adds one, writes destination, zero
// - destination bit 0 accumulator, 1 register, except literal OR which always writes accumulator
// - operand address is low seven bits
// - literal OR into accumulator, zero flag updated
// - register OR accumulator to destination, zero
// - copy register to destination, zero flag
// Purpose: execute four instructions of a small 8-bit core in one cycle each
// Assumes: file register read is combinational from fileAddr; other opcodes ignored
// Notes: accumulator and zero flag live here; file writes go out as a strobe
`timescale 1ns/1ns
`include "incor_defines.svh"
module increment_or_move_instructions #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int INSTR_W = 14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [DATA_W-1:0] fileRdata,
  output logic [ADDR_W-1:0] fileAddr,
  output incor_pkg::fileWrite_s fileWr,
  output logic [DATA_W-1:0] acc,
  output logic zeroFlag,
  output logic handled
);
  incor_pkg::op_e op;
  logic [7:0] aluResult;
  logic aluZero;
  logic [7:0] acc_reg, acc_next;
  logic zero_reg, zero_next;
  incor_pkg::fileWrite_s fileWr_reg, fileWr_next;
  logic destFile;

  function automatic incor_pkg::op_e decode(input logic [13:0] w);
    case (w[`OPC_MSB:`OPC_LSB])
      `OPC_INCREMENT: decode = incor_pkg::OP_INCREMENT;
      `OPC_OR_LIT: decode = incor_pkg::OP_OR_LIT;
      `OPC_OR_REG: decode = incor_pkg::OP_OR_REG;
      `OPC_COPY: decode = incor_pkg::OP_COPY;
      default: decode = incor_pkg::OP_NONE;
    endcase
  endfunction

  // the carrier structs and the opcode field layout fix these widths
  if (DATA_W != 8 || ADDR_W != 7 || INSTR_W != 14) begin : g_width_check
    $error("unsupported width parameters");
  end

  always_comb begin
    op = incor_pkg::OP_NONE;
    if (instrValid) begin
      op = decode(instr);
    end
  end
  assign fileAddr = instr[`ADDR_MSB:0];
  assign destFile = instr[`DEST_BIT] && (op != incor_pkg::OP_OR_LIT);
  assign handled = (op != incor_pkg::OP_NONE);

  incor_alu alu (
    .op(op),
    .acc(acc_reg),
    .fileVal(fileRdata),
    .literal(instr[7:0]),
    .result(aluResult),
    .isZero(aluZero)
  );

  always_comb begin
    acc_next = acc_reg;
    zero_next = zero_reg;
    fileWr_next = '0;
    if (handled) begin
      zero_next = aluZero;
      if (destFile) begin
        fileWr_next.writeEnable = 1'b1;
        fileWr_next.addr = fileAddr;
        fileWr_next.data = aluResult;
      end else begin
        acc_next = aluResult;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `ACC_RESET;
      zero_reg <= `ZERO_RESET;
      fileWr_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      zero_reg <= zero_next;
      fileWr_reg <= fileWr_next;
    end
  end

  assign acc = acc_reg;
  assign zeroFlag = zero_reg;
  assign fileWr = fileWr_reg;

  property p_inc_acc;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_INCREMENT && !instr[`DEST_BIT]) |=>
      acc == 8'($past(fileRdata) + 8'h01);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

  property p_dest_file;
    @(posedge ref_clk) disable iff (!rst_n)
    (handled && destFile) |=> fileWr.writeEnable && fileWr.addr == $past(instr[6:0])
      && acc == $past(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    handled |-> fileAddr == instr[6:0];
  endproperty
  a_addr: assert property (p_addr) else $error("address field wrong");

  property p_orlit;
    @(posedge ref_clk) disable iff (!rst_n)
    op == incor_pkg::OP_OR_LIT |=> acc == ($past(acc) | $past(instr[7:0])) && !fileWr.writeEnable;
  endproperty
  a_orlit: assert property (p_orlit) else $error("literal or wrong");

  property p_orreg;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_OR_REG && instr[`DEST_BIT]) |=>
      fileWr.data == ($past(acc) | $past(fileRdata));
  endproperty
  a_orreg: assert property (p_orreg) else $error("register or wrong");

  property p_copy;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_COPY && !instr[`DEST_BIT]) |=> acc == $past(fileRdata);
  endproperty
  a_copy: assert property (p_copy) else $error("copy wrong");

  property p_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    handled |=> zeroFlag == (fileWr.writeEnable ? fileWr.data == 8'h00 : acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !handled |=> $stable(acc) && $stable(zeroFlag) && !fileWr.writeEnable;
  endproperty
  a_hold: assert property (p_hold) else $error("state changed without instruction");

  property p_inc_file;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_INCREMENT && instr[`DEST_BIT]) |=>
      fileWr.writeEnable && fileWr.data == 8'($past(fileRdata) + 8'h01);
  endproperty
  a_inc_file: assert property (p_inc_file) else $error("increment to file wrong");

  property p_inc_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_INCREMENT && fileRdata == 8'hFF) |=>
      zeroFlag;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap zero wrong");

  property p_dest_acc;
    @(posedge ref_clk) disable iff (!rst_n)
    (handled && !instr[`DEST_BIT]) |=>
      !fileWr.writeEnable;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrote file");

  property p_wr_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    fileWr.writeEnable |->
      fileWr.addr == $past(instr[`ADDR_MSB:0]);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");

  property p_orlit_nz;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_OR_LIT && instr[7:0] != 8'h00) |=>
      !zeroFlag && acc != 8'h00;
  endproperty
  a_orlit_nz: assert property (p_orlit_nz) else $error("literal or zero flag wrong");

  property p_orreg_acc;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_OR_REG && !instr[`DEST_BIT]) |=>
      acc == ($past(acc) | $past(fileRdata)) && !fileWr.writeEnable;
  endproperty
  a_orreg_acc: assert property (p_orreg_acc) else $error("register or to acc wrong");

  property p_copy_file;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_COPY && instr[`DEST_BIT]) |=>
      fileWr.writeEnable && fileWr.data == $past(fileRdata) && acc == $past(acc);
  endproperty
  a_copy_file: assert property (p_copy_file) else $error("copy to file wrong");

  property p_copy_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (op == incor_pkg::OP_COPY) |=>
      zeroFlag == ($past(fileRdata) == 8'h00);
  endproperty
  a_copy_zero: assert property (p_copy_zero) else $error("copy zero test wrong");

  property p_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
    !instrValid |->
      !handled;
  endproperty
  a_refuse: assert property (p_refuse) else $error("instruction taken without valid");

  property p_wr_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
    fileWr.writeEnable |->
      $past(handled);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("file write without instruction");
endmodule

// file: hw/incor_defines.svh
// Purpose: constants for the increment/or/copy instruction slice
// Assumes: 14-bit instruction words, 8-bit data
// Notes: opcodes compare against the top six bits, literal op against top six as well
`ifndef INCOR_DEFINES_SVH
`define INCOR_DEFINES_SVH
`define OPC_INCREMENT 6'h0A
`define OPC_OR_REG 6'h04
`define OPC_COPY 6'h08
`define OPC_OR_LIT 6'h38
`define OPC_MSB 13
`define OPC_LSB 8
`define DEST_BIT 7
`define ADDR_MSB 6
`define ACC_RESET 8'h00
`define ZERO_RESET 1'b0
`endif

// file: hw/incor_pkg.sv
// Purpose: types for the increment/or/copy instruction slice
// Assumes: nothing beyond the defines header
// Notes: carrier structs for register file access and results
package incor_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_INCREMENT, OP_OR_LIT, OP_OR_REG, OP_COPY} op_e;
  typedef struct packed {
    logic writeEnable;
    logic [6:0] addr;
    logic [7:0] data;
  } fileWrite_s;
  typedef struct packed {
    logic valid;
    logic [7:0] value;
    logic toFile;
  } result_s;
endpackage

// file: hw/incor_alu.sv
// Purpose: combinational operation unit for the instruction slice
// Assumes: operands already selected
// Notes: computes result value and zero condition
`timescale 1ns/1ns
module incor_alu (
  input wire incor_pkg::op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fileVal,
  input wire logic [7:0] literal,
  output logic [7:0] result,
  output logic isZero
);
  always_comb begin
    case (op)
      incor_pkg::OP_INCREMENT: result = 8'(fileVal + 8'h01);
      incor_pkg::OP_OR_LIT: result = acc | literal;
      incor_pkg::OP_OR_REG: result = acc | fileVal;
      incor_pkg::OP_COPY: result = fileVal;
      default: result = acc;
    endcase
    isZero = (result == 8'h00);
  end
endmodule

// file: verification/increment_or_move_instructions_tb.sv
// Purpose: self-checking bench for the increment/or/copy slice
// Assumes: design answers on the taking edge itself; the bench checks at the next falling edge
// Notes: corner words first, then seeded random words
`timescale 1ns/1ns
module increment_or_move_instructions_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] fileRdata = 8'h00;
  logic [6:0] fileAddr;
  incor_pkg::fileWrite_s fileWr;
  logic [7:0] acc;
  logic zeroFlag;
  logic handled;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] expAcc = 8'h00;
  logic expZero = 1'b0;
  logic [15:0] expWr = 16'h0000;
  logic [13:0] corner [7] = '{14'h389A, 14'h3835, 14'h0A85, 14'h087F, 14'h04C3, 14'h0880, 14'h3F00};
  logic [7:0] cornerData [7] = '{8'h11, 8'h22, 8'hFF, 8'h00, 8'h40, 8'h00, 8'h00};
  logic [5:0] ops [5] = '{6'h0A, 6'h38, 6'h04, 6'h08, 6'h3F};

  always #2 ref_clk = ~ref_clk;

  increment_or_move_instructions dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .instrValid(instrValid),
    .instr(instr),
    .fileRdata(fileRdata),
    .fileAddr(fileAddr),
    .fileWr(fileWr),
    .acc(acc),
    .zeroFlag(zeroFlag),
    .handled(handled)
  );

  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] expv, input logic [15:0] seen);
    num_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // reference model of one instruction on the bench's own state
  task automatic model(input logic v, input logic [13:0] w, input logic [7:0] f);
    logic [7:0] r;
    logic ok;
    ok = v;
    case (w[13:8])
      6'h0A: r = f + 8'h01;
      6'h38: r = expAcc | w[7:0];
      6'h04: r = expAcc | f;
      6'h08: r = f;
      default: ok = 1'b0;
    endcase
    expWr = 16'h0000;
    if (ok) begin
      expZero = (r == 8'h00);
      if (w[13:8] != 6'h38 && w[7]) expWr = {1'b1, w[6:0], r};
      else expAcc = r;
    end
  endtask

  task automatic drive(input logic v, input logic [13:0] w, input logic [7:0] f);
    @(posedge ref_clk);
    instrValid <= v;
    instr <= w;
    fileRdata <= f;
    @(negedge ref_clk);
    cmp("acc", expAcc, acc);
    cmp("zeroFlag", expZero, zeroFlag);
    cmp("fileWr", expWr, fileWr);
    cmp("fileAddr", w[6:0], fileAddr);
    cmp("handled", v && (w[13:8] inside {6'h0A, 6'h38, 6'h04, 6'h08}), handled);
    model(v, w, f);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'h0E9E));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) drive(1'b1, corner[i], cornerData[i]);
    drive(1'b0, 14'h0A85, 8'hFF);
    // mid-run reset: state must fall back to its idle values
    @(posedge ref_clk);
    rst_n <= 1'b0;
    expAcc = 8'h00;
    expZero = 1'b0;
    expWr = 16'h0000;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (400) drive($urandom_range(0, 3) != 0, {ops[$urandom_range(0, 4)], 8'($urandom)}, 8'($urandom));
    drive(1'b0, 14'h0000, 8'h00);
    close_out();
  end
endmodule
